// *** rtl/i2cst_pkg.sv ***
package i2cst_pkg;

    // Core clock and the three supported bus rates
    localparam int I2CST_CLK_HZ = 200_000_000;
    localparam int I2CST_RATE_100K_HZ = 100_000;
    localparam int I2CST_RATE_400K_HZ = 400_000;
    localparam int I2CST_RATE_1M_HZ = 1_000_000;

    // Divider reloads: one tick per half SCL period
    localparam int I2CST_BRG_W = 10;
    localparam logic [9:0] I2CST_HALF_100K = 10'(I2CST_CLK_HZ / (2 * I2CST_RATE_100K_HZ) - 1);
    localparam logic [9:0] I2CST_HALF_400K = 10'(I2CST_CLK_HZ / (2 * I2CST_RATE_400K_HZ) - 1);
    localparam logic [9:0] I2CST_HALF_1M = 10'(I2CST_CLK_HZ / (2 * I2CST_RATE_1M_HZ) - 1);

    // Bit slots within a byte frame and the ten-bit address prefix
    localparam logic [3:0] I2CST_LAST_BIT = 4'h7;
    localparam logic [3:0] I2CST_ACK_SLOT = 4'h8;
    localparam logic [4:0] I2CST_TENBIT_PREFIX = 5'h1E;

    // Field positions of serial_control_two
    localparam int I2CST_C2_START = 0;
    localparam int I2CST_C2_RSTART = 1;
    localparam int I2CST_C2_STOP = 2;
    localparam int I2CST_C2_RCEN = 3;
    localparam int I2CST_C2_ACKDT = 5;
    localparam int I2CST_C2_ACKSTAT = 6;

    // Values after reset
    localparam logic I2CST_RELEASE_RST = 1'b1;
    localparam logic [7:0] I2CST_ADDR_RST = 8'h00;
    localparam logic [7:0] I2CST_BYTE_RST = 8'h00;

    typedef enum logic [1:0] {I2CST_RATE_100K, I2CST_RATE_400K, I2CST_RATE_1M} i2cst_rate_t;

    typedef enum logic [2:0] {S_IDLE, S_ADR1, S_ADR2, S_RXD, S_TXD} i2cst_sphase_t;

    typedef enum logic [3:0] {
        M_IDLE, M_ST1, M_ST2, M_HOLD, M_LOW, M_HIGH, M_SP1, M_SP2, M_SP3, M_RS1, M_RS2
    } i2cst_mstate_t;

endpackage

// *** rtl/i2cst_brg.sv ***
`timescale 1ns/10ps
module i2cst_brg import i2cst_pkg::*; #(
    parameter int BRG_W = I2CST_BRG_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic run,
    input wire logic [BRG_W-1:0] reload,
    output logic tick
);
    logic [BRG_W-1:0] cnt;

    if (BRG_W < I2CST_BRG_W) begin : g_width_check
        $error("i2cst_brg: BRG_W too narrow for the slowest bus rate");
    end

    // Reloaded while idle so the first tick comes a full half period after run rises
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (clk_en) begin
            if (!run || cnt == '0) begin
                cnt <= reload;
            end else begin
                cnt <= cnt - 1'b1;
            end
        end
    end

    assign tick = run && cnt == '0;

endmodule // i2cst_brg

// *** rtl/i2cst_core.sv ***
`timescale 1ns/10ps
module i2cst_core import i2cst_pkg::*; #(
    parameter int BRG_W = I2CST_BRG_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic port_enable,
    input wire logic mode_master,
    input wire logic addr_10bit,
    input wire logic [1:0] rate_sel,
    input wire logic sw_buf_wr,
    input wire logic [7:0] sw_buf_wdata,
    input wire logic sw_buf_rd,
    input wire logic sw_addr_wr,
    input wire logic [7:0] sw_addr_wdata,
    input wire logic sw_release_set,
    input wire logic sw_sen_wr,
    input wire logic sw_sen_wdata,
    input wire logic sw_stop_set,
    input wire logic sw_rstart_set,
    input wire logic sw_rcv_set,
    input wire logic ack_data,
    input wire logic sw_event_clr,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [7:0] buf_rdata,
    output logic [7:0] slave_address_register,
    output logic clock_release,
    output logic buffer_full_flag,
    output logic address_update_needed,
    output logic serial_port_event_flag,
    output logic [7:0] serial_control_two,
    output logic start_or_stretch_enable,
    output logic stop_enable,
    output logic slave_rw
);
    logic scl_q, sda_q;
    i2cst_sphase_t s_phase;
    logic [3:0] s_cnt;
    logic [7:0] s_shift;
    logic s_skip, s_ten_ok, s_acked, s_ack_drv, s_loaded, s_nack, addr_hold;
    i2cst_mstate_t m_state;
    logic [3:0] m_bit;
    logic [7:0] m_shift, shift_buffer;
    logic m_tx, ack_status, rstart_enable, rcv_enable;
    logic m_tick;

    if (BRG_W < I2CST_BRG_W) begin : g_width_check
        $error("i2cst_core: BRG_W too narrow for the slowest bus rate");
    end

    // Bus condition and edge decode from the previous pin sample
    wire scl_rise = scl_in && !scl_q;
    wire scl_fall = !scl_in && scl_q;
    wire bus_start = scl_in && scl_q && sda_q && !sda_in;
    wire bus_stop = scl_in && scl_q && !sda_q && sda_in;
    wire slave_on = port_enable && !mode_master;
    wire m_on = port_enable && mode_master;

    // Slave byte framing
    wire s_fall = slave_on && scl_fall && !s_skip && s_phase != S_IDLE;
    wire fall8 = s_fall && s_cnt == I2CST_LAST_BIT;
    wire fall9 = s_fall && s_cnt == I2CST_ACK_SLOT;
    wire ph_addr = s_phase == S_ADR1 || s_phase == S_ADR2;
    wire hi_match = s_shift[7:3] == I2CST_TENBIT_PREFIX && s_shift[2:1] == slave_address_register[2:1];
    // A read request on the high byte is only honoured after a matching write high byte since the last stop
    wire ack_adr1 = addr_10bit ? (hi_match && (!s_shift[0] || s_ten_ok))
                               : (s_shift[7:1] == slave_address_register[7:1]);
    wire ack_now = (s_phase == S_ADR1 && ack_adr1) || (s_phase == S_ADR2 && s_shift == slave_address_register)
                   || (s_phase == S_RXD && !buffer_full_flag) || s_phase == S_TXD;
    wire ua_set = fall8 && addr_10bit && ((s_phase == S_ADR1 && ack_adr1 && !s_shift[0])
                  || (s_phase == S_ADR2 && ack_now));
    wire rx_store = fall8 && s_phase == S_RXD && !buffer_full_flag;
    wire tx_load = slave_on && s_phase == S_TXD && s_cnt == 4'h0 && !s_loaded && buffer_full_flag;

    i2cst_sphase_t next_phase;
    assign next_phase = !s_acked ? S_IDLE
                      : s_phase == S_ADR1 ? (s_rw_dir() ? S_TXD : (addr_10bit ? S_ADR2 : S_RXD))
                      : s_phase == S_ADR2 ? S_RXD
                      : (s_phase == S_TXD && s_nack) ? S_IDLE : s_phase;

    function automatic logic s_rw_dir();
        return slave_rw;
    endfunction

    wire rx_stretch = fall9 && s_acked && s_phase == S_RXD && start_or_stretch_enable
                      && buffer_full_flag;
    wire tx_stretch = fall9 && next_phase == S_TXD && !buffer_full_flag;
    wire addr_stretch = fall9 && s_acked && ph_addr && address_update_needed;

    // Master sequencing
    wire m_done_byte = m_state == M_HIGH && m_tick && m_bit == I2CST_ACK_SLOT;
    wire m_tx_done = m_done_byte && m_tx;
    wire m_rx_done = m_done_byte && !m_tx;
    wire m_load = m_on && m_state == M_HOLD && !stop_enable && !rstart_enable && sw_buf_wr;
    wire m_rcv = m_on && m_state == M_HOLD && !stop_enable && !rstart_enable && !sw_buf_wr && rcv_enable;
    wire m_event = m_tick && (m_state == M_ST2 || m_state == M_SP3 || m_done_byte);
    // Holding the divider while SCL is held low by the slave keeps the high time honest
    wire brg_run = m_on && m_state != M_IDLE && m_state != M_HOLD && !(m_state == M_HIGH && !scl_in);
    wire [BRG_W-1:0] brg_reload = rate_sel == I2CST_RATE_1M ? BRG_W'(I2CST_HALF_1M)
                                : rate_sel == I2CST_RATE_400K ? BRG_W'(I2CST_HALF_400K)
                                : BRG_W'(I2CST_HALF_100K);

    i2cst_brg #(.BRG_W(BRG_W)) u_brg (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .run(brg_run),
        .reload(brg_reload),
        .tick(m_tick)
    );

    // Pin drive: open drain, low only while enabled
    wire m_bit_low = m_bit < I2CST_ACK_SLOT ? (m_tx && !m_shift[7]) : (!m_tx && !ack_data);
    wire m_scl_low = m_on && (m_state == M_ST2 || m_state == M_HOLD || m_state == M_LOW
                     || m_state == M_SP1 || m_state == M_RS1);
    wire m_sda_low = m_on && (m_state == M_ST1 || m_state == M_ST2 || m_state == M_SP1 || m_state == M_SP2
                     || ((m_state == M_LOW || m_state == M_HIGH) && m_bit_low));
    wire s_sda_low = slave_on && (s_ack_drv || (s_phase == S_TXD && s_cnt < I2CST_ACK_SLOT && s_loaded
                     && !s_shift[7]));
    assign scl_oe = m_scl_low || (slave_on && (!clock_release || addr_hold));
    assign sda_oe = m_sda_low || s_sda_low;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign buf_rdata = shift_buffer;

    always_comb begin
        serial_control_two = 8'h00;
        serial_control_two[I2CST_C2_START] = start_or_stretch_enable;
        serial_control_two[I2CST_C2_RSTART] = rstart_enable;
        serial_control_two[I2CST_C2_STOP] = stop_enable;
        serial_control_two[I2CST_C2_RCEN] = rcv_enable;
        serial_control_two[I2CST_C2_ACKDT] = ack_data;
        serial_control_two[I2CST_C2_ACKSTAT] = ack_status;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (clk_en) begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // Slave framing; a disable or a stop drops any transfer in flight
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_phase <= S_IDLE;
            s_cnt <= 4'h0;
            s_shift <= I2CST_BYTE_RST;
            s_skip <= 1'b0;
            s_ten_ok <= 1'b0;
            s_acked <= 1'b0;
            s_ack_drv <= 1'b0;
            s_loaded <= 1'b0;
            s_nack <= 1'b0;
            slave_rw <= 1'b0;
        end else if (clk_en) begin
            if (!slave_on || bus_stop) begin
                s_phase <= S_IDLE;
                s_ten_ok <= 1'b0;
                s_ack_drv <= 1'b0;
            end else if (bus_start) begin
                s_phase <= S_ADR1;
                s_cnt <= 4'h0;
                s_skip <= 1'b1;
                s_ack_drv <= 1'b0;
            end else if (scl_fall && s_skip) begin
                s_skip <= 1'b0;
            end else if (scl_rise && s_phase != S_IDLE) begin
                if (s_cnt < I2CST_ACK_SLOT && s_phase != S_TXD) begin
                    s_shift <= {s_shift[6:0], sda_in};
                end
                if (s_cnt == I2CST_ACK_SLOT) begin
                    s_nack <= sda_in;
                end
            end else if (fall8) begin
                s_cnt <= I2CST_ACK_SLOT;
                s_acked <= ack_now;
                s_ack_drv <= ack_now && s_phase != S_TXD;
                if (s_phase == S_ADR1) begin
                    slave_rw <= s_shift[0];
                end
                if (s_phase == S_ADR1 && ack_now && !s_shift[0]) begin
                    s_ten_ok <= addr_10bit;
                end
                if (s_phase == S_TXD) begin
                    s_shift <= {s_shift[6:0], 1'b0};
                end
            end else if (fall9) begin
                s_cnt <= 4'h0;
                s_ack_drv <= 1'b0;
                s_loaded <= 1'b0;
                s_phase <= next_phase;
            end else if (s_fall) begin
                s_cnt <= s_cnt + 4'h1;
                if (s_phase == S_TXD) begin
                    s_shift <= {s_shift[6:0], 1'b0};
                end
            end else if (tx_load) begin
                s_shift <= shift_buffer;
                s_loaded <= 1'b1;
            end
        end
    end

    // Stretch control; software setting the release wins over a receive or transmit stretch in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            clock_release <= I2CST_RELEASE_RST;
            address_update_needed <= 1'b0;
            addr_hold <= 1'b0;
            slave_address_register <= I2CST_ADDR_RST;
        end else if (clk_en) begin
            if (sw_addr_wr) begin
                slave_address_register <= sw_addr_wdata;
            end
            if (!port_enable || sw_release_set) begin
                clock_release <= 1'b1;
            end else if (rx_stretch || tx_stretch) begin
                clock_release <= 1'b0;
            end
            if (!port_enable) begin
                address_update_needed <= 1'b0;
            end else if (ua_set) begin
                address_update_needed <= 1'b1;
            end else if (sw_addr_wr) begin
                address_update_needed <= 1'b0;
            end
            if (!port_enable || sw_addr_wr) begin
                addr_hold <= 1'b0;
            end else if (addr_stretch) begin
                addr_hold <= 1'b1;
            end
        end
    end

    // Shift buffer and its full flag; hardware set wins over a software read
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            shift_buffer <= I2CST_BYTE_RST;
            buffer_full_flag <= 1'b0;
            serial_port_event_flag <= 1'b0;
        end else if (clk_en) begin
            if (sw_buf_wr) begin
                shift_buffer <= sw_buf_wdata;
            end else if (rx_store) begin
                shift_buffer <= s_shift;
            end else if (m_rx_done) begin
                shift_buffer <= m_shift;
            end
            if (!port_enable) begin
                buffer_full_flag <= 1'b0;
            end else if (sw_buf_wr || rx_store || m_rx_done) begin
                buffer_full_flag <= 1'b1;
            end else if (sw_buf_rd || tx_load || m_tx_done) begin
                buffer_full_flag <= 1'b0;
            end
            if (!port_enable) begin
                serial_port_event_flag <= 1'b0;
            end else if ((fall9 && s_acked) || m_event) begin
                serial_port_event_flag <= 1'b1;
            end else if (sw_event_clr) begin
                serial_port_event_flag <= 1'b0;
            end
        end
    end

    // Master command bits: software set wins, hardware clears start and stop when done, restart at the end of M_RS2, receive when the byte starts
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            start_or_stretch_enable <= 1'b0;
            stop_enable <= 1'b0;
            rstart_enable <= 1'b0;
            rcv_enable <= 1'b0;
        end else if (clk_en) begin
            if (sw_sen_wr) begin
                start_or_stretch_enable <= sw_sen_wdata;
            end else if (m_on && m_state == M_ST2 && m_tick) begin
                start_or_stretch_enable <= 1'b0;
            end
            stop_enable <= sw_stop_set || (stop_enable && m_on && !(m_state == M_SP3 && m_tick));
            rstart_enable <= sw_rstart_set || (rstart_enable && m_on && !(m_state == M_RS2 && m_tick));
            rcv_enable <= sw_rcv_set || (rcv_enable && m_on && !m_rcv);
        end
    end

    // Master bus sequencer; the whole byte including the ack takes nine clock pulses
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            m_state <= M_IDLE;
            m_bit <= 4'h0;
            m_shift <= I2CST_BYTE_RST;
            m_tx <= 1'b0;
            ack_status <= 1'b0;
        end else if (clk_en) begin
            if (!m_on) begin
                m_state <= M_IDLE;
            end else begin
                case (m_state)
                    M_IDLE: begin
                        if (start_or_stretch_enable) m_state <= M_ST1;
                    end
                    M_ST1: begin
                        if (m_tick) m_state <= M_ST2;
                    end
                    M_ST2: begin
                        if (m_tick) m_state <= M_HOLD;
                    end
                    M_HOLD: begin
                        if (stop_enable) begin
                            m_state <= M_SP1;
                        end else if (rstart_enable) begin
                            m_state <= M_RS1;
                        end else if (m_load || m_rcv) begin
                            m_shift <= sw_buf_wdata;
                            m_tx <= m_load;
                            m_bit <= 4'h0;
                            m_state <= M_LOW;
                        end
                    end
                    M_LOW: begin
                        if (m_tick) m_state <= M_HIGH;
                    end
                    M_HIGH: begin
                        if (m_tick && m_bit == I2CST_ACK_SLOT) begin
                            if (m_tx) ack_status <= sda_in;
                            m_state <= M_HOLD;
                        end else if (m_tick) begin
                            m_shift <= {m_shift[6:0], sda_in};
                            m_bit <= m_bit + 4'h1;
                            m_state <= M_LOW;
                        end
                    end
                    M_SP1: begin
                        if (m_tick) m_state <= M_SP2;
                    end
                    M_SP2: begin
                        if (m_tick) m_state <= M_SP3;
                    end
                    M_SP3: begin
                        if (m_tick) m_state <= M_IDLE;
                    end
                    M_RS1: begin
                        if (m_tick) m_state <= M_RS2;
                    end
                    M_RS2: begin
                        if (m_tick) m_state <= M_ST1;
                    end
                    default: m_state <= M_IDLE;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence tx_ninth_empty;
        fall9 && s_phase == S_TXD && s_acked && !s_nack && !buffer_full_flag && clk_en && !sw_release_set;
    endsequence
    sequence start_end;
        m_on && m_state == M_ST2 && m_tick && clk_en;
    endsequence
    sequence stop_end;
        m_on && m_state == M_SP3 && m_tick && clk_en;
    endsequence

    rx_stretch_a: assert property (
        (rx_stretch && clk_en && !sw_release_set) |=> !clock_release ##0 scl_oe)
        else $error("receive stretch did not pull SCL low");
    hold_low_a: assert property (
        (!clock_release && slave_on && !sw_release_set && clk_en) |=> !clock_release && scl_oe)
        else $error("clock released without software");
    release_set_a: assert property (
        (sw_release_set && clk_en) |=> clock_release)
        else $error("software release was lost");
    tx_stretch_a: assert property (
        tx_ninth_empty |=> !clock_release ##0 scl_oe)
        else $error("transmit with empty buffer did not stretch");
    addr_keep_a: assert property (
        (fall9 && ph_addr && clock_release && clk_en) |=> clock_release)
        else $error("release cleared during an address byte");
    addr_stretch_a: assert property (
        (addr_stretch && !sw_addr_wr && clk_en && slave_on) |=> scl_oe && clock_release)
        else $error("address update stretch missing");
    ua_clear_a: assert property (
        (sw_addr_wr && !ua_set && clk_en) |=> !address_update_needed && !addr_hold)
        else $error("address write did not release the stretch");
    start_flag_a: assert property (
        start_end |=> serial_port_event_flag && m_state == M_HOLD && scl_oe && !sda_oe)
        else $error("start condition did not raise the event flag");
    ack_store_a: assert property (
        (m_tx_done && m_on && clk_en) |=> ack_status == $past(sda_in) && serial_port_event_flag)
        else $error("acknowledge not stored after the ninth clock");
    msb_first_a: assert property (
        (m_load && clk_en) |=> sda_oe == !$past(sw_buf_wdata[7]) ##0 m_state == M_LOW)
        else $error("first bit shifted is not the MSB");
    stop_done_a: assert property (
        stop_end |=> m_state == M_IDLE && serial_port_event_flag && !stop_enable)
        else $error("stop completion not flagged");

endmodule // i2cst_core

// *** bench/i2cst_slave_model.sv ***
`timescale 1ns/10ps
module i2cst_slave_model (
    input wire logic clk_sys,
    input wire logic scl,
    input wire logic sda,
    input wire logic nack,
    output logic sda_oe,
    output logic [7:0] got
);
    logic p_scl = 1'b1;
    logic p_sda = 1'b1;
    logic [3:0] cnt = 4'h0;
    initial sda_oe = 1'b0;
    initial got = 8'h00;
    always @(posedge clk_sys) begin
        p_scl <= scl;
        p_sda <= sda;
        if (p_scl && scl && p_sda && !sda) begin
            cnt <= 4'h0;
        end else if (!p_scl && scl) begin
            cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
            if (cnt != 4'h8) begin
                got <= {got[6:0], sda};
            end
        end
        if (p_scl && !scl) begin
            // Acknowledge only from the fall after bit eight to the fall after bit nine
            sda_oe <= (cnt == 4'h8) && !nack;
        end
    end
endmodule // i2cst_slave_model

// *** bench/i2cst_core_bench.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; $display("mismatch %0t %h %h", $time, a, b); end end
module i2cst_core_bench;
    import i2cst_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, port_enable = 1'b1, sw_buf_wr = 1'b0, sw_buf_rd = 1'b0, sw_addr_wr = 1'b0;
    logic sw_release_set = 1'b0, sw_sen_wr = 1'b0, sw_sen_wdata = 1'b0, sw_stop_set = 1'b0, sw_rstart_set = 1'b0;
    logic sw_rcv_set = 1'b0, sw_event_clr = 1'b0, nack = 1'b0;
    logic [7:0] sw_buf_wdata = 8'h00, sw_addr_wdata = 8'h00, got, buf_rdata, slave_address_register, ctl2;
    logic scl_oe, sda_oe, m_oe, clock_release, buffer_full_flag, event_flag;
    logic [15:0] lo = 16'h0, half = 16'h0;
    int err_count = 0, compares = 0, cyc = 0;
    wire scl = !scl_oe;
    wire sda = !(sda_oe || m_oe);
    i2cst_core dut (.clk_sys, .rst_n, .clk_en(1'b1), .port_enable, .mode_master(1'b1), .addr_10bit(1'b0),
        .rate_sel(2'h2), .sw_buf_wr, .sw_buf_wdata, .sw_buf_rd, .sw_addr_wr, .sw_addr_wdata, .sw_release_set,
        .sw_sen_wr, .sw_sen_wdata, .sw_stop_set, .sw_rstart_set, .sw_rcv_set, .ack_data(1'b0), .sw_event_clr,
        .scl_in(scl), .scl_out(), .scl_oe, .sda_in(sda), .sda_out(), .sda_oe, .buf_rdata, .slave_address_register,
        .clock_release, .buffer_full_flag, .address_update_needed(), .serial_port_event_flag(event_flag),
        .serial_control_two(ctl2), .start_or_stretch_enable(), .stop_enable(), .slave_rw());
    i2cst_slave_model partner (.clk_sys, .scl, .sda, .nack, .sda_oe(m_oe), .got);
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        lo <= scl ? 16'h0 : lo + 16'h1;
        if (scl && lo != 16'h0) half <= lo;
        cyc++;
        // Five bytes plus the starts, repeated start and stop need far fewer cycles than this
        if (cyc == 40000) begin
            err_count++;
            finish_test;
        end
    end
    task automatic finish_test;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic go(input logic [4:0] s, input logic [7:0] d, input logic w);
        int n;
        n = 0;
        @(negedge clk_sys);
        {sw_sen_wr, sw_buf_wr, sw_stop_set, sw_rstart_set, sw_rcv_set} = s;
        sw_sen_wdata = s[4];
        sw_buf_wdata = d;
        @(negedge clk_sys);
        {sw_sen_wr, sw_buf_wr, sw_stop_set, sw_rstart_set, sw_rcv_set} = 5'h0;
        while (w && event_flag !== 1'b1 && n < 8000) begin
            @(negedge clk_sys);
            n++;
        end
        if (w) begin
            `CHK(event_flag, 1'b1)
            sw_event_clr = 1'b1;
            @(negedge clk_sys);
            sw_event_clr = 1'b0;
        end
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        `CHK({clock_release, scl_oe, sda_oe, event_flag}, 4'h8)
        go(5'h10, 8'h00, 1'b1);
        `CHK({scl, sda}, 2'h1)
        go(5'h08, 8'hA4, 1'b1);
        `CHK(got, 8'hA4)
        `CHK(ctl2[I2CST_C2_ACKSTAT], 1'b0)
        `CHK(half, 16'(I2CST_HALF_1M) + 16'h1)
        nack = 1'b1;
        go(5'h08, 8'h3C, 1'b1);
        `CHK(got, 8'h3C)
        `CHK(ctl2[I2CST_C2_ACKSTAT], 1'b1)
        nack = 1'b0;
        go(5'h02, 8'h00, 1'b1);
        go(5'h08, 8'hA5, 1'b1);
        go(5'h01, 8'h00, 1'b1);
        `CHK(buf_rdata, 8'hFF)
        go(5'h04, 8'h00, 1'b1);
        `CHK({scl, sda}, 2'h3)
        sw_addr_wr = 1'b1;
        sw_addr_wdata = 8'h5A;
        sw_buf_rd = 1'b1;
        sw_release_set = 1'b1;
        @(negedge clk_sys);
        {sw_addr_wr, sw_buf_rd, sw_release_set} = 3'h0;
        `CHK({slave_address_register, buffer_full_flag, clock_release}, 10'h169)
        go(5'h10, 8'h00, 1'b1);
        go(5'h08, 8'hC3, 1'b0);
        repeat (300) @(negedge clk_sys);
        port_enable = 1'b0;
        repeat (2) @(negedge clk_sys);
        `CHK({scl_oe, sda_oe, event_flag, clock_release}, 4'h1)
        finish_test;
    end
endmodule // i2cst_core_bench
